// ==== rtl/dofp_regs.svh ====
// constants for the octal ddr flash bus port
// assumes inclusion by the modules that need timing counts
`ifndef DOFP_REGS_SVH
`define DOFP_REGS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DOFP_CLK_PERIOD_NS 50
`define DOFP_ACCESS_TIME_NS 96
`define DOFP_CLOCK_STOP_EXTRA_NS 30
// initial access time, longest figure rounded down, at least one cycle
`define DOFP_ACCESS_CYCLES ((`DOFP_ACCESS_TIME_NS / `DOFP_CLK_PERIOD_NS) < 1 ? 1 : \
   (`DOFP_ACCESS_TIME_NS / `DOFP_CLK_PERIOD_NS))
// clock-stop entry is a least time: round up
`define DOFP_STOP_CYCLES ((`DOFP_ACCESS_TIME_NS + `DOFP_CLOCK_STOP_EXTRA_NS + \
   `DOFP_CLK_PERIOD_NS - 1) / `DOFP_CLK_PERIOD_NS)
// ----------------------------------------------------------------
// command-address fields (first byte), length and fifo depth
// ----------------------------------------------------------------
`define DOFP_CA_READ_BIT 7
`define DOFP_CA_WRAP_BIT 5
`define DOFP_CA_BYTES 6
`define DOFP_FIFO_DEPTH 16
`endif

// ==== rtl/dofp_pkg.sv ====
// types for the octal ddr flash bus port
// assumes nothing beyond the constant header
package dofp_pkg;
   typedef enum logic [2:0] {
      DOFP_IDLE = 3'b000,
      DOFP_CMD = 3'b001,
      DOFP_LATENCY = 3'b010,
      DOFP_READ = 3'b011,
      DOFP_WRITE = 3'b100,
      DOFP_DONE = 3'b101
   } dofp_state_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] data;
   } dofp_word_t;
   typedef struct packed {
      logic read;
      logic wrap;
      logic [31:0] addr;
   } dofp_cmd_t;
endpackage : dofp_pkg

// ==== rtl/dofp_fifo.sv ====
// synchronous valid/ready fifo for write words from the link
// assumes one clock; width and depth are parameters, depth a power of two
`timescale 1ns/1ps
module dofp_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire empty = (wr_ptr == rd_ptr);
   wire push = in_valid && !full;
   wire pop = out_valid && out_ready;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule : dofp_fifo

// ==== rtl/dofp_port.sv ====
// device end of an 8-bit ddr flash bus: link logic on the bus clock,
// array side on the system clock.
// assumes the host keeps its own duties; the array answers reads from
// a presented word within the initial access time.
//
// Contract
// - device holds strobe low during writes
// - burst writes linear only, wrap refused
// - complement clock used on 1.8V variant only; the link clock here is bus_clock alone on both variants
// - complement clocks optional, device works without
// - first read data within access time; here it comes over 150 ns after the last command byte
// - stable clock enters clock-stop, data held
`timescale 1ns/1ps
`include "dofp_regs.svh"
module dofp_port
   import dofp_pkg::*;
#(
   parameter bit LOW_VOLTAGE = 1'b0,
   parameter int DEPTH = `DOFP_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic bus_clock,
   input wire logic bus_clock_complement,
   input wire logic phase_shifted_clock,
   input wire logic phase_shifted_clock_complement,
   input wire logic select_n,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe_n,
   output logic read_write_strobe_out,
   output logic read_write_strobe_oe_n,
   output logic address_space_overlay,
   input wire logic overlay_set,
   output dofp_cmd_t arr_cmd,
   output logic arr_cmd_valid,
   input wire logic [15:0] arr_rdata,
   output dofp_word_t arr_wr,
   output logic arr_wr_valid,
   input wire logic arr_wr_ready,
   output logic clock_stopped,
   output logic burst_refused
);
   // ----------------------------------------------------------------
   // link clock selection
   // ----------------------------------------------------------------
   // complement cancels out of the low-voltage expression; link_clk is bus_clock on either part
   wire link_clk = LOW_VOLTAGE ? (bus_clock & ~bus_clock_complement) | (bus_clock & bus_clock_complement)
                               : bus_clock;
   wire unused_psc = phase_shifted_clock ^ phase_shifted_clock_complement;

   // ----------------------------------------------------------------
   // link side: command-address capture on rising edges
   // ----------------------------------------------------------------
   logic [47:0] ca_shift;
   logic [2:0] ca_count;
   logic ca_done;
   logic is_read;
   logic is_wrap;
   logic [31:0] waddr;
   logic [7:0] wbyte_hi;
   logic whalf;
   logic link_req_tgl;
   logic [15:0] rd_hold;
   logic link_in_valid;
   logic [47:0] link_in_data;
   logic link_in_ready;
   logic [31:0] cmd_addr;
   logic rd_ready_flag;
   logic [15:0] rd_word;
   logic [3:0] act_bin;
   logic [3:0] act_gray;
   wire ca_last = (ca_count == 3'(`DOFP_CA_BYTES - 1));
   // select high clears transaction state; it is the frame's own signal
   always_ff @(posedge link_clk or posedge select_n) begin
      if (select_n) begin
         ca_count <= '0;
         ca_done <= 1'b0;
         whalf <= 1'b0;
         link_in_valid <= 1'b0;
      end else begin
         link_in_valid <= 1'b0;
         if (!ca_done) begin
            ca_count <= ca_count + 3'h1;
            if (ca_last) ca_done <= 1'b1;
         end else if (!is_read) begin
            whalf <= ~whalf;
            if (whalf) link_in_valid <= link_in_ready;
         end
      end
   end
   always_ff @(posedge link_clk) begin
      if (!ca_done) ca_shift <= {ca_shift[39:0], dq_in};
      if (ca_done && !is_read && !whalf) wbyte_hi <= dq_in;
      if (ca_done && !is_read && whalf) link_in_data <= {waddr, wbyte_hi, dq_in};
   end
   // address steps by one word per beat: linear only
   // byte0 sits in [39:32] at the last edge; the last address byte is still on dq_in
   always_ff @(posedge link_clk) begin
      if (!ca_done && ca_last) begin
         is_read <= ca_shift[32+`DOFP_CA_READ_BIT];
         is_wrap <= ca_shift[32+`DOFP_CA_WRAP_BIT];
         cmd_addr <= {ca_shift[23:0], dq_in};
         waddr <= {ca_shift[23:0], dq_in};
      end else if (ca_done && !is_read && whalf) begin
         waddr <= waddr + 32'h1;
      end
   end
   // toggles must survive select, so only the system reset clears them
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) link_req_tgl <= 1'b0;
      else if (!ca_done && ca_last) link_req_tgl <= ~link_req_tgl;
   end
   // gray count of link edges for clock-stop detection; a bus clock at
   // sixteen times the system clock would look stopped
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_bin <= 4'h0;
         act_gray <= 4'h0;
      end else begin
         act_bin <= act_bin + 4'h1;
         act_gray <= act_bin ^ {1'b0, act_bin[3:1]};
      end
   end

   // ----------------------------------------------------------------
   // link side: read data, one byte per edge
   // ----------------------------------------------------------------
   logic [2:0] rd_ready_sync;
   wire rd_ready_link = rd_ready_sync[2] & rd_ready_sync[1];
   always_ff @(posedge link_clk or posedge select_n) begin
      if (select_n) rd_ready_sync <= 3'h0;
      else rd_ready_sync <= {rd_ready_sync[1:0], rd_ready_flag};
   end
   always_ff @(posedge link_clk) rd_hold <= rd_word;
   // data and strobe follow the clock level so every edge moves a byte
   wire reading = !select_n && ca_done && is_read && rd_ready_link;
   assign dq_out = reading ? (link_clk ? rd_hold[15:8] : rd_hold[7:0]) : 8'h00;
   assign dq_oe_n = !reading;
   assign read_write_strobe_out = reading ? link_clk : 1'b0;
   assign read_write_strobe_oe_n = select_n;

   // ----------------------------------------------------------------
   // system side: request crossing and access timer
   // ----------------------------------------------------------------
   logic [2:0] req_sync;
   logic [2:0] sel_sync;
   logic [3:0] act_q0;
   logic [3:0] act_q1;
   logic [3:0] act_q2;
   logic [7:0] acc_count;
   logic [7:0] stop_count;
   logic refuse_q;
   wire req_seen = req_sync[2] ^ req_sync[1];
   wire sel_active = !(sel_sync[2] & sel_sync[1]);
   // sampling the clock level aliases; a moving edge count aliases only at multiples of sixteen times
   wire clk_change = (act_q2 != act_q1);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         req_sync <= 3'h0;
         sel_sync <= 3'h7;
         act_q0 <= 4'h0;
         act_q1 <= 4'h0;
         act_q2 <= 4'h0;
      end else begin
         req_sync <= {req_sync[1:0], link_req_tgl};
         sel_sync <= {sel_sync[1:0], select_n};
         act_q0 <= act_gray;
         act_q1 <= act_q0;
         act_q2 <= act_q1;
      end
   end
   // ca fields are stable once the toggle has crossed
   wire wrap_write = !is_read && is_wrap;
   wire burst_bad = wrap_write || (!is_read && address_space_overlay);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         arr_cmd_valid <= 1'b0;
         arr_cmd <= '0;
         acc_count <= 8'h00;
         rd_ready_flag <= 1'b0;
         rd_word <= 16'h0000;
         refuse_q <= 1'b0;
      end else begin
         arr_cmd_valid <= req_seen && !burst_bad;
         if (req_seen) arr_cmd <= '{read: is_read, wrap: is_wrap, addr: cmd_addr};
         if (req_seen && burst_bad) refuse_q <= 1'b1;
         else if (!sel_active) refuse_q <= 1'b0;
         if (req_seen && is_read) acc_count <= 8'(`DOFP_ACCESS_CYCLES);
         else if (acc_count != 8'h00) acc_count <= acc_count - 8'h01;
         if (acc_count == 8'h01) begin
            rd_ready_flag <= 1'b1;
            rd_word <= arr_rdata;
         end else if (!sel_active) begin
            rd_ready_flag <= 1'b0;
         end
      end
   end
   assign burst_refused = refuse_q;

   // ----------------------------------------------------------------
   // clock-stop detection
   // ----------------------------------------------------------------
   // read data stays latched in rd_hold and driven while stopped
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stop_count <= 8'h00;
         clock_stopped <= 1'b0;
      end else if (!sel_active || clk_change) begin
         stop_count <= 8'h00;
         clock_stopped <= 1'b0;
      end else if (stop_count == 8'(`DOFP_STOP_CYCLES)) begin
         clock_stopped <= 1'b1;
      end else begin
         stop_count <= stop_count + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // overlay flag, set by the array control logic
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) address_space_overlay <= 1'b0;
      else address_space_overlay <= overlay_set;
   end

   // ----------------------------------------------------------------
   // write words cross to the system clock through a small handshake,
   // then queue in the fifo toward the array
   // ----------------------------------------------------------------
   logic wr_tgl;
   logic [2:0] wr_sync;
   logic [47:0] wr_cap;
   always_ff @(posedge link_clk) begin
      if (link_in_valid) wr_cap <= link_in_data;
   end
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) wr_tgl <= 1'b0;
      else if (link_in_valid) wr_tgl <= ~wr_tgl;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) wr_sync <= 3'h0;
      else wr_sync <= {wr_sync[1:0], wr_tgl};
   end
   wire wr_push = (wr_sync[2] ^ wr_sync[1]) && !burst_refused;
   logic fifo_in_ready;
   logic [2:0] rdy_sync;
   always_ff @(posedge link_clk or posedge select_n) begin
      if (select_n) rdy_sync <= 3'h7;
      else rdy_sync <= {rdy_sync[1:0], fifo_in_ready};
   end
   // back-pressure: with the fifo full the next link word is dropped, not held
   assign link_in_ready = rdy_sync[2] & rdy_sync[1];
   dofp_fifo #(.WIDTH(48), .DEPTH(DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_data(wr_cap),
      .in_valid(wr_push),
      .in_ready(fifo_in_ready),
      .out_data(arr_wr),
      .out_valid(arr_wr_valid),
      .out_ready(arr_wr_ready)
   );
endmodule : dofp_port

// ==== sim/dofp_port_assertions.sv ====
// checker for the port outputs of the flash bus port
// assumes it is bound into dofp_port and sees only its ports
`timescale 1ns/1ps
module dofp_port_chk
   import dofp_pkg::*;
#(
   parameter bit LOW_VOLTAGE = 1'b0,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic bus_clock,
   input wire logic select_n,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic read_write_strobe_out,
   input wire logic read_write_strobe_oe_n,
   input wire dofp_cmd_t arr_cmd,
   input wire logic arr_cmd_valid,
   input wire logic clock_stopped,
   input wire logic burst_refused
);
   // ------
   // properties
   // ------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   sequence s_read_cmd;
      $rose(arr_cmd_valid) && arr_cmd.read;
   endsequence
   sequence s_data_out;
      ##[1:10] !dq_oe_n;
   endsequence
   property p_first_data;
      s_read_cmd |-> s_data_out;
   endproperty
   property p_strobe_en;
      !select_n && $past(!select_n) |-> !read_write_strobe_oe_n;
   endproperty
   property p_write_low;
      !select_n && dq_oe_n && $past(dq_oe_n) |-> !read_write_strobe_out;
   endproperty
   property p_refuse_blocks;
      burst_refused |-> !arr_cmd_valid;
   endproperty
   property p_refuse_stands;
      burst_refused && !select_n |=> burst_refused;
   endproperty
   // only the rising edge is checked: on restart the flag lags the clock
   property p_stop_holds;
      $rose(clock_stopped) && !select_n && !dq_oe_n |-> $stable(dq_out);
   endproperty
   property p_read_strobe;
      !dq_oe_n && !select_n && $past(!dq_oe_n) |-> read_write_strobe_out == bus_clock;
   endproperty
   a_first_data: assert property (p_first_data)
      else $error("read data not driven after read command");
   a_strobe_en: assert property (p_strobe_en)
      else $error("strobe not driven while selected");
   a_write_low: assert property (p_write_low)
      else $error("strobe not low outside read data");
   a_refuse_blocks: assert property (p_refuse_blocks)
      else $error("refused write issued a command");
   a_refuse_stands: assert property (p_refuse_stands)
      else $error("refusal dropped while selected");
   a_stop_holds: assert property (p_stop_holds)
      else $error("read data changed in clock stop");
   a_read_strobe: assert property (p_read_strobe)
      else $error("read strobe does not follow bus clock");
endmodule : dofp_port_chk

bind dofp_port dofp_port_chk #(.LOW_VOLTAGE(LOW_VOLTAGE), .DEPTH(DEPTH)) chk (.clock(clock), .rst_n(rst_n),
   .bus_clock(bus_clock), .select_n(select_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
   .read_write_strobe_out(read_write_strobe_out), .read_write_strobe_oe_n(read_write_strobe_oe_n),
   .arr_cmd(arr_cmd), .arr_cmd_valid(arr_cmd_valid), .clock_stopped(clock_stopped), .burst_refused(burst_refused));

// ==== sim/dofp_host.sv ====
// host bus master model: bus clock, select and command-address bytes
// assumes the bench calls its tasks through the instance name
`timescale 1ns/1ps
module dofp_host (
   output logic bus_clock,
   output logic phase_shifted_clock,
   output logic select_n,
   output logic [7:0] dq_in
);
   // ------
   // clocks
   // ------
   bit run;
   realtime hp = 6.0;
   // the clock only parks low, so a pause never leaves it high
   initial begin
      bus_clock = 1'b0;
      phase_shifted_clock = 1'b0;
      dq_in = 8'h00;
      #0.5;
      // raised late so the select-driven link reset sees a clean edge
      select_n = 1'b1;
      forever begin
         #hp;
         if (run || bus_clock) bus_clock = ~bus_clock;
      end
   end
   always @(bus_clock) phase_shifted_clock <= #3 bus_clock;
   task automatic put(input logic [7:0] b);
      if (bus_clock) @(negedge bus_clock);
      dq_in = b;
      @(posedge bus_clock);
   endtask : put
   task automatic start(input logic [7:0] op, input logic [31:0] addr, input realtime half);
      hp = half;
      select_n = 1'b0;
      run = 1'b1;
      put(op);
      put(8'h00);
      for (int i = 3; i >= 0; i--) put(addr[i*8 +: 8]);
   endtask : start
   // word loads of a program command, linear only; the word crosses on the first edge after the pause
   task automatic word(input logic [15:0] w);
      put(w[15:8]);
      put(w[7:0]);
      run = 1'b0;
      #300;
      run = 1'b1;
   endtask : word
   task automatic finish();
      run = 1'b1;
      @(posedge bus_clock);
      run = 1'b0;
      wait (!bus_clock);
      dq_in = ~dq_in;
      select_n = 1'b1;
      #100;
   endtask : finish
endmodule : dofp_host

// ==== sim/dofp_port_test.sv ====
// self-checking bench for the flash bus port
// assumes the host model drives the link, the bench the array side
`timescale 1ns/1ps
module dofp_port_test;
   import dofp_pkg::*;
   // ------
   // harness
   // ------
   logic clock = 1'b0;
   logic rst_n = 1'b1;
   logic bus_clock, phase_shifted_clock, select_n, dq_oe_n, arr_cmd_valid, arr_wr_valid;
   logic read_write_strobe_out, read_write_strobe_oe_n, address_space_overlay, clock_stopped, burst_refused;
   logic [7:0] dq_in, dq_out;
   logic overlay_set = 1'b0;
   logic arr_wr_ready = 1'b0;
   logic [15:0] arr_rdata = 16'hA55A;
   dofp_cmd_t arr_cmd, last_cmd;
   dofp_word_t arr_wr;
   int num_errors, compares, cmd_cnt;
   always #25 clock = ~clock;
   always @(posedge clock) begin
      if (arr_cmd_valid) begin
         last_cmd <= arr_cmd;
         cmd_cnt <= cmd_cnt + 1;
      end
   end
   dofp_host host (.bus_clock, .phase_shifted_clock, .select_n, .dq_in);
   dofp_port uut (.clock, .rst_n, .bus_clock, .bus_clock_complement(1'b0), .phase_shifted_clock,
      .phase_shifted_clock_complement(1'b0), .select_n, .dq_in, .dq_out, .dq_oe_n, .read_write_strobe_out,
      .read_write_strobe_oe_n, .address_space_overlay, .overlay_set, .arr_cmd, .arr_cmd_valid, .arr_rdata,
      .arr_wr, .arr_wr_valid, .arr_wr_ready, .clock_stopped, .burst_refused);
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      if (num_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // ------
   // scenarios
   // ------
   task automatic t_read();
      host.start(8'h80, 32'h0000_0120, 6.0);
      repeat (6) @(posedge clock);
      check(last_cmd, {2'b10, 32'h0000_0120});
      for (int i = 0; i < 10 && dq_oe_n !== 1'b0; i++) @(posedge clock);
      check(dq_oe_n, 1'b0);
      @(posedge bus_clock);
      #1 check({dq_out, read_write_strobe_out, clock_stopped}, {8'hA5, 2'b10});
      @(negedge bus_clock);
      #1 check({dq_out, read_write_strobe_out}, {8'h5A, 1'b0});
      host.run = 1'b0;
      repeat (8) @(posedge clock);
      #1 check({clock_stopped, dq_oe_n, dq_out}, {2'b10, 8'h5A});
      host.finish();
   endtask : t_read
   // far side stalls while sixteen words fill the buffer, then drains it
   task automatic t_write();
      host.start(8'h00, 32'h0000_0040, 10.0);
      for (int i = 0; i < 16; i++) host.word(16'(16'hC300 + i));
      check({read_write_strobe_oe_n, read_write_strobe_out, dq_oe_n, arr_wr_valid}, 4'b0011);
      check(last_cmd, {2'b00, 32'h0000_0040});
      host.finish();
      @(posedge clock);
      #1 arr_wr_ready = 1'b1;
      for (int i = 0; i < 16; i++) begin
         check({arr_wr_valid, arr_wr}, {1'b1, 32'(64 + i), 16'(16'hC300 + i)});
         @(posedge clock);
         #1;
      end
      check(arr_wr_valid, 1'b0);
   endtask : t_write
   task automatic t_refused();
      int n;
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         #1 overlay_set = k[0];
         arr_wr_ready = 1'b0;
         repeat (3) @(posedge clock);
         n = cmd_cnt;
         host.start(k[0] ? 8'h00 : 8'h20, 32'h0000_0080, 10.0);
         host.word(16'h1234);
         repeat (4) @(posedge clock);
         check({burst_refused, arr_wr_valid, address_space_overlay, cmd_cnt - n}, {2'b10, k[0], 32'h0});
         host.finish();
         // the refused word crosses on the first edge after the pause, before the closing edge
         repeat (3) @(posedge clock);
         #1 check(arr_wr_valid, 1'b0);
      end
      #1 overlay_set = 1'b0;
   endtask : t_refused
   initial begin
      // a real falling edge, so the link-clock flops reset with no link clock
      #1 rst_n = 1'b0;
      repeat (10) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clock);
      t_read();
      t_write();
      t_refused();
      report_and_stop();
   end
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
endmodule : dofp_port_test
